// File: hdl/pcrc_engine.sv
// programmable crc engine: apb registers, input fifo control, shift engine, events
//
// Functional notes
// - shifting starts only once shift_go is one
// - fifo depth 8 if length above 7, else 16
// - byte writes accepted; surplus high data bits ignored
// - element width is length field plus one
// - writing word's top part bumps valid_word_count
// - go and count nonzero moves word, decrements count
// - fetch until zero; last bits leave later
// - full flag at depth, empty flag at zero
// - write while full wraps count, no event
// - event on count going one to zero
// - stop_in_idle freezes engine in idle; events pass
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
module pcrc_engine (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pcrc_pkg::pcrc_apb_req_s apb_i,
  input wire logic idle_i,
  output pcrc_pkg::pcrc_apb_rsp_s apb_o,
  output logic irq_o
);
  import pcrc_pkg::*;

  // one lfsr step, data bit enters at the top of the programmed width
  function automatic logic [DATA_W-1:0] crc_step(input logic [DATA_W-1:0] c, input logic b,
                                                 input logic [3:0] poly_length_field, input logic [DATA_W-1:0] poly,
                                                 input logic [DATA_W-1:0] m);
    logic fb;
    fb = c[poly_length_field] ^ b;
    crc_step = ({c[DATA_W-2:0], 1'b0} ^ (fb ? poly : CRC_RST)) & m;
  endfunction

  // control and software-visible registers
  logic [3:0] poly_length_field_q, poly_length_field_d; // poly_length_field
  logic go_q, go_d; // shift_go
  logic sidl_q, sidl_d; // stop_in_idle
  logic [DATA_W-1:0] poly_q, poly_d; // feedback taps
  logic [IRQ_W-1:0] istat_q, istat_d; // sticky events
  logic [IRQ_W-1:0] ien_q, ien_d; // event enables
  logic [7:0] lo_q, lo_d; // staged low byte of a wide word
  logic irq_q, irq_d; // interrupt output register
  pcrc_apb_rsp_s rsp_q, rsp_d; // bus answer register

  // fifo bookkeeping
  logic [CNT_W-1:0] count_q, count_d; // valid_word_count
  logic [PTR_W-1:0] wptr_q, wptr_d;
  logic [PTR_W-1:0] rptr_q, rptr_d;

  // shift engine
  pcrc_eng_e st_q, st_d;
  logic [DATA_W-1:0] sh_q, sh_d; // word being shifted out
  logic [DATA_W-1:0] crc_q, crc_d; // running result
  logic [CNT_W-1:0] brem_q, brem_d; // bits still to shift

  // combinational helpers
  logic setup; // apb setup cycle
  logic wr_acc; // apb write taking effect
  logic data_wr; // write to the data register
  logic clr_pulse; // result clear request
  logic push; // a complete word is written
  logic wrap; // write while full
  logic pop; // word moves to the engine
  logic held; // frozen by idle
  logic full; // fifo_full_flag
  logic empty; // fifo_empty_flag
  logic [CNT_W-1:0] depth; // current fifo depth
  logic [PTR_W-1:0] pmask; // pointer wrap mask
  logic [DATA_W-1:0] wmask; // element width mask
  logic [DATA_W-1:0] pdat; // word pushed into the fifo
  logic [DATA_W-1:0] mem_rdata; // word read from the fifo
  logic drain_ev; // count one to zero
  logic done_ev; // engine finished with count at zero
  logic [31:0] rd_mux; // register read value
  logic mapped; // address hits a register

  // static decodes
  always_comb begin
    held = sidl_q & idle_i;
    depth = (poly_length_field_q > POLY_LENGTH_FIELD_SPLIT) ? DEPTH_SHALLOW : DEPTH_DEEP;
    pmask = (poly_length_field_q > POLY_LENGTH_FIELD_SPLIT) ? PTR_MASK_SHALLOW : PTR_MASK_DEEP;
    full = (count_q == depth);
    empty = (count_q == '0);
    wmask = 16'hFFFF >> (4'hF - poly_length_field_q);
    setup = apb_i.psel & ~apb_i.penable;
    wr_acc = apb_i.psel & apb_i.penable & rsp_q.pready & apb_i.pwrite;
    data_wr = wr_acc & (apb_i.paddr == OFF_DATA);
    clr_pulse = wr_acc & (apb_i.paddr == OFF_CTRL) & apb_i.pstrb[0] & apb_i.pwdata[CTRL_CLR_BIT];
  end

  // word assembly from byte or wider writes
  always_comb begin
    push = 1'b0;
    lo_d = lo_q;
    pdat = CRC_RST;
    if (data_wr) begin
      if (poly_length_field_q <= POLY_LENGTH_FIELD_SPLIT) begin
        // whole element sits in the low byte
        push = apb_i.pstrb[0];
        pdat = apb_i.pwdata[15:0] & wmask;
      end else if (apb_i.pstrb[1]) begin
        // top byte completes the word
        push = 1'b1;
        pdat = {apb_i.pwdata[15:8], (apb_i.pstrb[0] ? apb_i.pwdata[7:0] : lo_q)} & wmask;
      end else if (apb_i.pstrb[0]) begin
        // low byte only, hold it for later
        lo_d = apb_i.pwdata[7:0];
      end
    end
  end

  // fifo pointers and valid_word_count
  always_comb begin
    wrap = push & full;
    pop = go_q & ~empty & ~held & ~wrap &
          ((st_q == ENG_IDLE) | ((st_q == ENG_SHIFT) & (brem_q <= 5'h02)));
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    count_d = count_q;
    drain_ev = 1'b0;
    if (wrap) begin
      // overrun: fifo starts over as empty, no event raised
      count_d = '0;
      wptr_d = '0;
      rptr_d = '0;
    end else begin
      if (push) begin
        wptr_d = (wptr_q + 4'h1) & pmask;
      end
      if (pop) begin
        rptr_d = (rptr_q + 4'h1) & pmask;
      end
      // net change of the count
      if (push & ~pop) begin
        count_d = count_q + 5'h01;
      end else if (pop & ~push) begin
        count_d = count_q - 5'h01;
        drain_ev = (count_q == 5'h01);
      end
    end
  end

  // fifo registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
      wptr_q <= '0;
      rptr_q <= '0;
      lo_q <= 8'h00;
    end else begin
      count_q <= count_d;
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      lo_q <= lo_d;
    end
  end

  // fifo storage
  pcrc_fifo_mem u_mem (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(push & ~wrap),
    .wr_addr_i(wptr_q),
    .wr_data_i(pdat),
    .rd_en_i(pop),
    .rd_addr_i(rptr_q),
    .rd_data_o(mem_rdata)
  );

  // shift engine next state
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    crc_d = crc_q;
    brem_d = brem_q;
    done_ev = 1'b0;
    if (!held) begin
      unique case (st_q)
        ENG_IDLE: begin
          if (pop) begin
            st_d = ENG_LOAD;
          end
        end
        ENG_LOAD: begin
          // fifo read data is valid now
          sh_d = mem_rdata & wmask;
          brem_d = {1'b0, poly_length_field_q} + 5'h01;
          st_d = ENG_SHIFT;
        end
        ENG_SHIFT: begin
          // first bit of the pair
          crc_d = crc_step(crc_q, sh_q[poly_length_field_q], poly_length_field_q, poly_q, wmask);
          sh_d = {sh_q[DATA_W-2:0], 1'b0};
          if (brem_q >= 5'h02) begin
            // second bit of the pair
            crc_d = crc_step(crc_d, sh_d[poly_length_field_q], poly_length_field_q, poly_q, wmask);
            sh_d = {sh_d[DATA_W-2:0], 1'b0};
            brem_d = brem_q - 5'h02;
          end else begin
            brem_d = '0;
          end
          if (brem_q <= 5'h02) begin
            // word finished: next word or rest
            st_d = pop ? ENG_LOAD : ENG_IDLE;
            done_ev = ~pop & empty;
          end
        end
      endcase
    end
    if (clr_pulse) begin
      crc_d = CRC_RST;
    end
  end

  // shift engine registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= ENG_IDLE;
      sh_q <= CRC_RST;
      crc_q <= CRC_RST;
      brem_q <= '0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      crc_q <= crc_d;
      brem_q <= brem_d;
    end
  end

  // register read mux and address decode
  always_comb begin
    rd_mux = RDATA_RST;
    mapped = 1'b1;
    unique case (apb_i.paddr)
      OFF_CTRL: begin
        rd_mux[CTRL_POLY_LENGTH_FIELD_LSB +: 4] = poly_length_field_q;
        rd_mux[CTRL_GO_BIT] = go_q;
        rd_mux[CTRL_SIDL_BIT] = sidl_q;
        rd_mux[CTRL_VW_LSB +: CNT_W] = count_q;
        rd_mux[CTRL_FULL_BIT] = full;
        rd_mux[CTRL_EMPTY_BIT] = empty;
      end
      OFF_DATA: begin
        rd_mux[DATA_W-1:0] = crc_q;
      end
      OFF_POLY: begin
        rd_mux[DATA_W-1:0] = poly_q;
      end
      OFF_ISTAT: begin
        rd_mux[IRQ_W-1:0] = istat_q;
      end
      OFF_ICLR: begin
        rd_mux = RDATA_RST;
      end
      OFF_IEN: begin
        rd_mux[IRQ_W-1:0] = ien_q;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // control registers, events and bus answer
  always_comb begin
    poly_length_field_d = poly_length_field_q;
    go_d = go_q;
    sidl_d = sidl_q;
    poly_d = poly_q;
    ien_d = ien_q;
    istat_d = istat_q;
    // answer in the cycle after setup, no wait states
    rsp_d.pready = setup;
    rsp_d.pslverr = setup & ~mapped;
    rsp_d.prdata = (setup & ~apb_i.pwrite) ? rd_mux : RDATA_RST;
    if (wr_acc) begin
      unique case (apb_i.paddr)
        OFF_CTRL: begin
          if (apb_i.pstrb[0]) begin
            poly_length_field_d = apb_i.pwdata[CTRL_POLY_LENGTH_FIELD_LSB +: 4];
            go_d = apb_i.pwdata[CTRL_GO_BIT];
            sidl_d = apb_i.pwdata[CTRL_SIDL_BIT];
          end
        end
        OFF_POLY: begin
          if (apb_i.pstrb[0]) begin
            poly_d[7:0] = apb_i.pwdata[7:0];
          end
          if (apb_i.pstrb[1]) begin
            poly_d[15:8] = apb_i.pwdata[15:8];
          end
        end
        OFF_ICLR: begin
          if (apb_i.pstrb[0]) begin
            istat_d = istat_q & ~apb_i.pwdata[IRQ_W-1:0];
          end
        end
        OFF_IEN: begin
          if (apb_i.pstrb[0]) begin
            ien_d = apb_i.pwdata[IRQ_W-1:0];
          end
        end
        default: begin
          istat_d = istat_q;
        end
      endcase
    end
    // new events win over a clear in the same cycle
    istat_d[IRQ_DRAIN_BIT] = istat_d[IRQ_DRAIN_BIT] | drain_ev;
    istat_d[IRQ_DONE_BIT] = istat_d[IRQ_DONE_BIT] | done_ev;
    // events still reach the output while frozen
    irq_d = |(istat_q & ien_q);
  end

  // control registers and outputs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      poly_length_field_q <= POLY_LENGTH_FIELD_RST;
      go_q <= 1'b0;
      sidl_q <= 1'b0;
      poly_q <= POLY_RST;
      ien_q <= IRQ_RST;
      istat_q <= IRQ_RST;
      irq_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      poly_length_field_q <= poly_length_field_d;
      go_q <= go_d;
      sidl_q <= sidl_d;
      poly_q <= poly_d;
      ien_q <= ien_d;
      istat_q <= istat_d;
      irq_q <= irq_d;
      rsp_q <= rsp_d;
    end
  end

  assign apb_o = rsp_q;
  assign irq_o = irq_q;
endmodule

// File: hdl/pcrc_pkg.sv
// package of shared constants and types for the programmable crc fifo engine
package pcrc_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CTRL = 8'h00; // crc_control_reg
  localparam logic [7:0] OFF_DATA = 8'h04; // crc_write_data_reg, read gives result
  localparam logic [7:0] OFF_POLY = 8'h08; // feedback tap pattern
  localparam logic [7:0] OFF_ISTAT = 8'h0C; // sticky event status, read only
  localparam logic [7:0] OFF_ICLR = 8'h10; // write one to clear status, write only
  localparam logic [7:0] OFF_IEN = 8'h14; // event enable mask

  // control register field positions
  localparam int CTRL_POLY_LENGTH_FIELD_LSB = 0; // poly_length_field, 4 bits
  localparam int CTRL_GO_BIT = 4; // shift_go
  localparam int CTRL_SIDL_BIT = 5; // stop_in_idle
  localparam int CTRL_CLR_BIT = 6; // write one clears result, reads zero
  localparam int CTRL_VW_LSB = 8; // valid_word_count, 5 bits
  localparam int CTRL_FULL_BIT = 13; // fifo_full_flag
  localparam int CTRL_EMPTY_BIT = 14; // fifo_empty_flag

  // event bit positions in status and enable
  localparam int IRQ_DRAIN_BIT = 0; // count went from one to zero
  localparam int IRQ_DONE_BIT = 1; // last bit left the shift engine
  localparam int IRQ_W = 2;

  // sizes
  localparam int DATA_W = 16; // widest data element
  localparam int MEM_DEPTH = 16; // physical fifo entries
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [3:0] POLY_LENGTH_FIELD_SPLIT = 4'h7; // above this the fifo is shallow
  localparam logic [CNT_W-1:0] DEPTH_SHALLOW = 5'h08;
  localparam logic [CNT_W-1:0] DEPTH_DEEP = 5'h10;
  localparam logic [PTR_W-1:0] PTR_MASK_SHALLOW = 4'h7;
  localparam logic [PTR_W-1:0] PTR_MASK_DEEP = 4'hF;

  // reset values
  localparam logic [3:0] POLY_LENGTH_FIELD_RST = 4'h0;
  localparam logic [DATA_W-1:0] POLY_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CRC_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // engine states
  typedef enum logic [1:0] {ENG_IDLE, ENG_LOAD, ENG_SHIFT} pcrc_eng_e;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } pcrc_apb_req_s;

  // apb answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pcrc_apb_rsp_s;

endpackage

// File: hdl/pcrc_fifo_mem.sv
// fifo storage array with registered read data
`timescale 1ns/100ps
module pcrc_fifo_mem (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [pcrc_pkg::PTR_W-1:0] wr_addr_i,
  input wire logic [pcrc_pkg::DATA_W-1:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [pcrc_pkg::PTR_W-1:0] rd_addr_i,
  output logic [pcrc_pkg::DATA_W-1:0] rd_data_o
);
  import pcrc_pkg::*;

  logic [DATA_W-1:0] mem_q [MEM_DEPTH]; // entries, no reset needed
  logic [DATA_W-1:0] rd_q; // read data register
  logic [DATA_W-1:0] rd_d;

  // next read data
  always_comb begin
    rd_d = rd_en_i ? mem_q[rd_addr_i] : rd_q;
  end

  // array write
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // read register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_q <= CRC_RST;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data_o = rd_q;
endmodule

// File: tb/pcrc_engine_sva.sv
// port checker for the crc engine, bound to the top module
`timescale 1ns/100ps
module pcrc_engine_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pcrc_pkg::pcrc_apb_req_s apb_i,
  input wire logic idle_i,
  input wire pcrc_pkg::pcrc_apb_rsp_s apb_o,
  input wire logic irq_o
);
  import pcrc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // control register read answered this cycle
  wire logic rd_ctrl = apb_o.pready && !apb_i.pwrite && apb_i.paddr == OFF_CTRL;
  wire logic [4:0] vw = apb_o.prdata[12:8]; // word count field
  AST_READY_NEXT: assert property (apb_i.psel && !apb_i.penable |=> apb_o.pready)
    else $error("setup not answered next cycle");
  AST_READY_ACCESS: assert property (apb_o.pready |-> apb_i.psel && apb_i.penable)
    else $error("ready outside access phase");
  AST_ERR_UNMAPPED: assert property (apb_i.psel && !apb_i.penable && apb_i.paddr > OFF_IEN |=> apb_o.pslverr)
    else $error("unmapped access without error");
  AST_ERR_READY: assert property (apb_o.pslverr |-> apb_o.pready)
    else $error("error without ready");
  AST_RDATA_IDLE: assert property (!apb_o.pready |-> apb_o.prdata == RDATA_RST)
    else $error("read data outside answer");
  AST_EMPTY_ZERO: assert property (rd_ctrl |-> apb_o.prdata[CTRL_EMPTY_BIT] == (vw == 5'h00))
    else $error("empty flag disagrees with count");
  AST_FULL_DEPTH: assert property (rd_ctrl |-> apb_o.prdata[CTRL_FULL_BIT] ==
    (vw == ((apb_o.prdata[3:0] > POLY_LENGTH_FIELD_SPLIT) ? DEPTH_SHALLOW : DEPTH_DEEP)))
    else $error("full flag disagrees with depth");
  AST_COUNT_BOUND: assert property (rd_ctrl |-> vw <= DEPTH_DEEP && apb_o.prdata[31:15] == 17'h0_0000)
    else $error("count out of range");
  AST_IRQ_RESET: assert property ($rose(rst_n_i) |-> !irq_o)
    else $error("interrupt high after reset");
  // main scenarios reached
  cover property (rd_ctrl && apb_o.prdata[CTRL_FULL_BIT]);
  cover property ($rose(irq_o));
  cover property (apb_o.pslverr);
endmodule
bind pcrc_engine pcrc_engine_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .idle_i(idle_i),
  .apb_o(apb_o), .irq_o(irq_o));

// File: tb/pcrc_engine_bench.sv
// self-checking bench for the crc engine over apb
`timescale 1ns/100ps
module pcrc_engine_bench;
  import pcrc_pkg::*;
  logic clk_i = 1'b0; // system clock
  logic rst_n_i = 1'b0; // reset, held at start
  logic idle_i = 1'b0; // cpu idle request
  pcrc_apb_req_s req = '0; // apb master request
  pcrc_apb_rsp_s rsp; // apb answer
  logic irq_o; // interrupt line
  int mismatches = 0;
  int n_checks = 0;
  logic [31:0] rd; // last read data
  logic err; // last slave error
  logic [15:0] crc; // expected result
  logic [3:0] pl; // length under test
  logic [4:0] dp; // depth under test
  logic [7:0] dat [3] = '{8'hFF, 8'h6A, 8'h95}; // bytes with top bits set
  pcrc_engine dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(req), .idle_i(idle_i), .apb_o(rsp), .irq_o(irq_o));
  // 50 mhz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // verdict and end of run
  task automatic close_out();
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, waits for ready under a bound
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    req.pstrb <= s;
    @(posedge clk_i);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    if (rsp.pready !== 1'b1) begin
      mismatches++;
      close_out();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // full word write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask
  // read and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rd, e);
  endtask
  // read until masked value matches, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      xfer(1'b0, a, 32'h0000_0000, 4'h0);
      n++;
    end while ((rd & m) !== v && n < 64);
    chk(rd & m, v);
    if ((rd & m) !== v) begin
      close_out();
    end
  endtask
  // expected control register image
  function automatic logic [31:0] ctl(input logic [3:0] p, input logic [4:0] c, input logic f, input logic [1:0] gs);
    return {17'h0_0000, c == 5'h00, f, c, 2'b00, gs, p};
  endfunction
  // reference lfsr, msb first, element of p+1 bits
  function automatic logic [15:0] crc_step(input logic [3:0] p, input logic [15:0] poly, input logic [15:0] c,
    input logic [15:0] w);
    logic [15:0] m;
    logic fb;
    m = 16'hFFFF >> (4'hF - p);
    for (int i = 15; i >= 0; i--) begin
      if (i <= p) begin
        fb = c[p] ^ w[i];
        c = ((c << 1) ^ (fb ? poly : 16'h0000)) & m;
      end
    end
    return c;
  endfunction
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdchk(OFF_CTRL, ctl(4'h0, 5'h00, 1'b0, 2'b00));
    rdchk(OFF_DATA, 32'h0000_0000);
    xfer(1'b0, 8'h40, 32'h0000_0000, 4'h0);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    // six-bit elements, only the drain event enabled
    wr(OFF_IEN, 32'h0000_0001);
    wr(OFF_POLY, 32'h0000_0021);
    wr(OFF_CTRL, 32'h0000_0005);
    crc = CRC_RST;
    foreach (dat[i]) begin
      wr(OFF_DATA, {24'hFF_FFFF, dat[i]});
      crc = crc_step(4'h5, 16'h0021, crc, {8'h00, dat[i]});
    end
    repeat (8) @(posedge clk_i);
    rdchk(OFF_CTRL, ctl(4'h5, 5'h03, 1'b0, 2'b00));
    // go while idle and stop-in-idle: nothing moves
    idle_i <= 1'b1;
    wr(OFF_CTRL, 32'h0000_0035);
    repeat (8) @(posedge clk_i);
    rdchk(OFF_CTRL, ctl(4'h5, 5'h03, 1'b0, 2'b11));
    idle_i <= 1'b0;
    poll(OFF_ISTAT, 32'h0000_0003, 32'h0000_0003);
    // frozen again: status, clear and irq must still pass
    idle_i <= 1'b1;
    rdchk(OFF_CTRL, ctl(4'h5, 5'h00, 1'b0, 2'b11));
    rdchk(OFF_DATA, {16'h0000, crc});
    chk({31'h0000_0000, irq_o}, 32'h0000_0001);
    wr(OFF_ICLR, 32'h0000_0001);
    rdchk(OFF_ISTAT, 32'h0000_0002);
    chk({31'h0000_0000, irq_o}, 32'h0000_0000);
    idle_i <= 1'b0;
    wr(OFF_ICLR, 32'h0000_0003);
    wr(OFF_CTRL, 32'h0000_0040);
    // fill to full at both depths, then wrap
    for (int k = 0; k < 2; k++) begin
      pl = (k == 1) ? 4'h8 : 4'h3;
      dp = (k == 1) ? DEPTH_SHALLOW : DEPTH_DEEP;
      wr(OFF_CTRL, {28'h000_0000, pl});
      for (int i = 0; i < dp; i++) begin
        wr(OFF_DATA, 32'h0000_0001);
      end
      rdchk(OFF_CTRL, ctl(pl, dp, 1'b1, 2'b00));
      wr(OFF_DATA, 32'h0000_0001);
      rdchk(OFF_CTRL, ctl(pl, 5'h00, 1'b0, 2'b00));
    end
    rdchk(OFF_ISTAT, 32'h0000_0000);
    // nine-bit element sent as two byte writes
    xfer(1'b1, OFF_DATA, 32'h0000_00A5, 4'h1);
    rdchk(OFF_CTRL, ctl(4'h8, 5'h00, 1'b0, 2'b00));
    xfer(1'b1, OFF_DATA, 32'h0000_5A00, 4'h2);
    rdchk(OFF_CTRL, ctl(4'h8, 5'h01, 1'b0, 2'b00));
    wr(OFF_CTRL, 32'h0000_0018);
    poll(OFF_CTRL, 32'h0000_4000, 32'h0000_4000);
    poll(OFF_ISTAT, 32'h0000_0003, 32'h0000_0003);
    rdchk(OFF_DATA, {16'h0000, crc_step(4'h8, 16'h0021, 16'h0000, 16'h5AA5)});
    close_out();
  end
endmodule
